/* tit_cfg.svh */
`ifndef TIT_CFG_SVH
`define TIT_CFG_SVH
`define TIT_OFF_CNT0 8'h20
`define TIT_OFF_CNT1 8'h24
`define TIT_OFF_CNT2 8'h28
`define TIT_OFF_CTRL 8'h2c
`define TIT_SEL_HI 7
`define TIT_SEL_LO 6
`define TIT_ACC_HI 5
`define TIT_ACC_LO 4
`define TIT_MODE_HI 3
`define TIT_MODE_LO 1
`define TIT_BCD_BIT 0
`define TIT_RB_CNT_N 5
`define TIT_RB_STA_N 4
`define TIT_SYS_HZ 100000000
`define TIT_CNT_HZ 10000000
`define TIT_DIV_CYC (`TIT_SYS_HZ / `TIT_CNT_HZ)
`endif

/* tit_pkg.sv */
package tit_pkg;
	typedef enum logic [1:0] {TIT_ACC_LATCH, TIT_ACC_LSB, TIT_ACC_MSB, TIT_ACC_BOTH} tit_acc_t;
	typedef struct packed {
		logic [1:0] acc;
		logic [2:0] mode;
		logic bcd;
	} tit_cfg_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tit_bus_t;
	typedef enum logic {TIT_BYTE_LO, TIT_BYTE_HI} tit_byte_t;
endpackage

/* tit_timer.sv */
// Our own choice: strobed register access.
`timescale 1ns/100ps
`include "tit_cfg.svh"
// Functional notes
// - three 16-bit counters, counts 2..65535
// - internal 10 MHz count clock
// - counter zero internal or external event clock
// - counters one, two cascaded; rising out triggers
// - data at 0x20/0x24/0x28, control 0x2c
// - counts move as low and high bytes
// - control fields select, access, mode, bcd
// - select 11 means read-back command
// - access latch, low, high, low-then-high
// - mode decode, top bit ignored modes 2,3
// - binary or bcd counting
// - read-back latches chosen counts or status
// - null count set on write, cleared on load
// - mode 0 high at terminal count
// - mode 0 first byte halts, second restarts
// - mode 1 retriggerable one-shot
// - mode 2 rate generator, one-clock low
// - mode 3 square wave, odd split
// - mode 4 one-clock strobe at terminal count
// - mode 5 gate-triggered strobe
// - latch command holds count for reads
module tit_timer (
	input wire logic clk_in,
	input wire logic nrst_in,
	input tit_pkg::tit_bus_t bus_in,
	output logic [7:0] rdata_out,
	input wire logic ext_clk_sel_in,
	input wire logic external_event_clock_in,
	input wire logic first_counter_gate_in,
	input wire logic [2:1] gate_in,
	output logic [2:0] cnt_out,
	output logic conv_trig_out
);
	import tit_pkg::*;
	logic [3:0] div_r;
	logic tick_r;
	logic [1:0] ext_sync_r;
	logic ext_prev_r;
	logic [2:0] g_s1_r, g_s2_r;
	logic [2:0] cen;
	logic out2_prev_r;
	logic out1_prev_r;
	logic sel_cnt;
	logic [1:0] sel_idx;
	logic rd_hit_r;
	logic [2:0][7:0] rd_byte;

	assign sel_cnt = bus_in.addr == `TIT_OFF_CNT0 || bus_in.addr == `TIT_OFF_CNT1 ||
		bus_in.addr == `TIT_OFF_CNT2;
	assign sel_idx = bus_in.addr[3:2];

	// 10 MHz count enable from 100 MHz system clock
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_r <= 4'h0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= div_r == 4'((`TIT_DIV_CYC) - 1);
			div_r <= (div_r == 4'((`TIT_DIV_CYC) - 1)) ? 4'h0 : div_r + 4'h1;
		end
	end

	// external clock and gates synchronised; first stage feeds only second
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ext_sync_r <= 2'h0;
			ext_prev_r <= 1'b0;
			g_s1_r <= 3'h0;
			g_s2_r <= 3'h0;
			out2_prev_r <= 1'b1;
		end else begin
			ext_sync_r <= {ext_sync_r[0], external_event_clock_in};
			ext_prev_r <= ext_sync_r[1];
			g_s1_r <= {gate_in, first_counter_gate_in};
			g_s2_r <= g_s1_r;
			out2_prev_r <= cnt_out[2];
		end
	end

	// counter zero picks timer or event clock; one and two form the pacer chain
	assign cen[0] = ext_clk_sel_in ? (ext_sync_r[1] & ~ext_prev_r) : tick_r;
	assign cen[1] = tick_r;
	assign cen[2] = cnt_out[1] & ~out1_prev_r;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			out1_prev_r <= 1'b1;
			conv_trig_out <= 1'b0;
		end else begin
			out1_prev_r <= cnt_out[1];
			conv_trig_out <= cnt_out[2] & ~out2_prev_r;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_cnt
			tit_cfg_t cfg_r;
			logic [15:0] cnt_r, init_r, hold_r;
			logic [7:0] lsb_r;
			logic out_r, null_r, armed_r, run_r, trig_r, gprev_r, odd_ph_r;
			logic hold_v_r, stat_v_r, wb_r, rb_r;
			logic [7:0] stat_r;
			logic wr_dat, wr_ctl, rb_hit, rd_me, gate, gedge, ce;
			logic [15:0] dec1, dec2, dec3, nxt;
			logic [2:0] md;
			assign gate = g_s2_r[i];
			assign gedge = gate & ~gprev_r;
			assign ce = cen[i];
			assign md = cfg_r.mode[1] ? {1'b0, cfg_r.mode[1:0]} : cfg_r.mode;
			assign wr_dat = bus_in.wr && sel_cnt && sel_idx == 2'(i);
			assign wr_ctl = bus_in.wr && bus_in.addr == `TIT_OFF_CTRL &&
				bus_in.wdata[`TIT_SEL_HI:`TIT_SEL_LO] == 2'(i);
			assign rb_hit = bus_in.wr && bus_in.addr == `TIT_OFF_CTRL &&
				bus_in.wdata[7:6] == 2'h3 && bus_in.wdata[i + 1];
			assign rd_me = bus_in.rd && sel_cnt && sel_idx == 2'(i);

			// bcd-aware decrement by k
			function automatic logic [15:0] dec_k(input logic [15:0] v, input logic bcd,
				input logic [1:0] k);
				logic [15:0] r;
				r = v;
				for (int n = 0; n < 3; n++) begin
					if (n < k) begin
						if (!bcd)
							r = r - 16'h1;
						else if (r[3:0] != 4'h0)
							r = r - 16'h1;
						else if (r[7:4] != 4'h0)
							r = {r[15:8], r[7:4] - 4'h1, 4'h9};
						else if (r[11:8] != 4'h0)
							r = {r[15:12], r[11:8] - 4'h1, 8'h99};
						else
							r = {(r[15:12] == 4'h0) ? 4'h9 : r[15:12] - 4'h1, 12'h999};
					end
				end
				return r;
			endfunction
			assign dec1 = dec_k(cnt_r, cfg_r.bcd, 2'd1);
			assign dec2 = dec_k(cnt_r, cfg_r.bcd, 2'd2);
			assign dec3 = dec_k(cnt_r, cfg_r.bcd, 2'd3);

			// control write, count bytes, null count, latches
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					cfg_r <= '0;
					init_r <= 16'h0;
					lsb_r <= 8'h0;
					wb_r <= 1'b0;
					rb_r <= 1'b0;
					armed_r <= 1'b0;
					null_r <= 1'b1;
					hold_r <= 16'h0;
					hold_v_r <= 1'b0;
					stat_r <= 8'h0;
					stat_v_r <= 1'b0;
				end else begin
					if (wr_ctl && bus_in.wdata[5:4] == 2'h0) begin
						if (!hold_v_r) begin
							hold_r <= cnt_r;
							hold_v_r <= 1'b1;
						end
					end else if (wr_ctl) begin
						cfg_r <= '{acc: bus_in.wdata[`TIT_ACC_HI:`TIT_ACC_LO],
							mode: bus_in.wdata[`TIT_MODE_HI:`TIT_MODE_LO],
							bcd: bus_in.wdata[`TIT_BCD_BIT]};
						wb_r <= 1'b0;
						rb_r <= 1'b0;
						armed_r <= 1'b0;
						null_r <= 1'b1;
						hold_v_r <= 1'b0;
						stat_v_r <= 1'b0;
					end else if (wr_dat) begin
						unique case (tit_acc_t'(cfg_r.acc))
							TIT_ACC_LSB: begin
								init_r <= {8'h0, bus_in.wdata};
								armed_r <= 1'b1;
								null_r <= 1'b1;
							end
							TIT_ACC_MSB: begin
								init_r <= {bus_in.wdata, 8'h0};
								armed_r <= 1'b1;
								null_r <= 1'b1;
							end
							TIT_ACC_BOTH: begin
								if (wb_r == TIT_BYTE_LO) begin
									lsb_r <= bus_in.wdata;
									armed_r <= 1'b0;
								end else begin
									init_r <= {bus_in.wdata, lsb_r};
									armed_r <= 1'b1;
									null_r <= 1'b1;
								end
								wb_r <= ~wb_r;
							end
							TIT_ACC_LATCH: ;
						endcase
					end else if (trig_r && ce) begin
						null_r <= 1'b0;
					end
					if (rb_hit && !bus_in.wdata[`TIT_RB_CNT_N] && !hold_v_r) begin
						hold_r <= cnt_r;
						hold_v_r <= 1'b1;
					end
					if (rb_hit && !bus_in.wdata[`TIT_RB_STA_N] && !stat_v_r) begin
						stat_r <= {out_r, null_r, cfg_r};
						stat_v_r <= 1'b1;
					end
					if (rd_me) begin
						if (stat_v_r)
							stat_v_r <= 1'b0;
						else if (cfg_r.acc != 2'h3 || rb_r)
							hold_v_r <= 1'b0;
						if (!stat_v_r && cfg_r.acc == 2'h3)
							rb_r <= ~rb_r;
					end
				end
			end

			// pending load: set by written count or gate trigger, cleared on the load tick
			always_comb begin
				trig_r = 1'b0;
				unique case (md)
					3'd0, 3'd4: trig_r = armed_r && !run_r;
					3'd1, 3'd5: trig_r = armed_r && gedge;
					default: trig_r = armed_r && (!run_r || gedge);
				endcase
			end
			always_comb begin
				nxt = dec1;
				if (md == 3'd3)
					nxt = (odd_ph_r && cnt_r[0]) ? (out_r ? dec1 : dec3) : dec2;
			end

			// counting element and output
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					cnt_r <= 16'h0;
					out_r <= 1'b1;
					run_r <= 1'b0;
					gprev_r <= 1'b0;
					odd_ph_r <= 1'b0;
				end else begin
					// edge held until the count tick, so a gate that rises between ticks still triggers if it is still high at the tick
					if (ce)
						gprev_r <= gate;
					if (wr_ctl && bus_in.wdata[5:4] != 2'h0) begin
						out_r <= bus_in.wdata[3:1] != 3'h0;
						run_r <= 1'b0;
					end else if (wr_dat && md == 3'd0) begin
						out_r <= 1'b0;
						run_r <= 1'b0;
					end else if (wr_dat && md == 3'd4) begin
						run_r <= 1'b0;
					end else if (md inside {3'd2, 3'd3} && !gate) begin
						out_r <= 1'b1;
						run_r <= 1'b0;
					end else if (ce && trig_r) begin
						cnt_r <= init_r;
						run_r <= 1'b1;
						odd_ph_r <= 1'b1;
						if (md == 3'd1)
							out_r <= 1'b0;
					end else if (ce && (gate || md == 3'd1 || md == 3'd5) && run_r) begin
						cnt_r <= nxt;
						odd_ph_r <= 1'b0;
						unique case (md)
							3'd0: if (nxt == 16'h0) out_r <= 1'b1;
							3'd1: if (nxt == 16'h0) out_r <= 1'b1;
							3'd2: begin
								out_r <= nxt != 16'h1;
								if (cnt_r == 16'h1) begin
									cnt_r <= init_r;
									out_r <= 1'b1;
								end
							end
							3'd3: if (nxt == 16'h0 || cnt_r <= 16'h2) begin
								cnt_r <= init_r;
								out_r <= ~out_r;
								odd_ph_r <= 1'b1;
							end
							3'd4, 3'd5: out_r <= !(nxt == 16'h0 && out_r);
							default: ;
						endcase
					end else if (ce && md inside {3'd4, 3'd5})
						out_r <= 1'b1;
				end
			end
			assign cnt_out[i] = out_r;

			// read mux: status first, then held count, then live count
			logic [15:0] rv;
			assign rv = hold_v_r ? hold_r : cnt_r;
			always_comb begin
				rd_byte[i] = rv[7:0];
				if (stat_v_r)
					rd_byte[i] = stat_r;
				else if (cfg_r.acc == 2'h2 || (cfg_r.acc == 2'h3 && rb_r))
					rd_byte[i] = rv[15:8];
			end

			// strobe lasts one count clock, so it must end at the next count tick
			property p_strobe_one;
				@(posedge clk_in) disable iff (!nrst_in)
					md == 3'd4 && run_r && !out_r && ce && !wr_ctl && !wr_dat |=> out_r;
			endproperty
			a_strobe_one: assert property (p_strobe_one) else $error("strobe low too long");
		end
	endgenerate

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_hit_r <= 1'b0;
			rdata_out <= 8'h0;
		end else begin
			rd_hit_r <= bus_in.rd && sel_cnt;
			rdata_out <= (bus_in.rd && sel_cnt) ? rd_byte[sel_idx] : 8'h0;
		end
	end

	property p_trig;
		@(posedge clk_in) disable iff (!nrst_in) $rose(cnt_out[2]) |=> conv_trig_out;
	endproperty
	a_trig: assert property (p_trig) else $error("no trigger on pacer rise");
	property p_tick;
		@(posedge clk_in) disable iff (!nrst_in) tick_r |=> !tick_r [*8];
	endproperty
	a_tick: assert property (p_tick) else $error("count clock not 10 MHz");
	property p_trig_one;
		@(posedge clk_in) disable iff (!nrst_in) conv_trig_out |=> !conv_trig_out;
	endproperty
	a_trig_one: assert property (p_trig_one) else $error("trigger wider than one");
	property p_rd_zero;
		@(posedge clk_in) disable iff (!nrst_in) !bus_in.rd |=> rdata_out == 8'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
	property p_ctrl_rd;
		@(posedge clk_in) disable iff (!nrst_in)
			bus_in.rd && bus_in.addr == `TIT_OFF_CTRL |=> rdata_out == 8'h0;
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control reads nonzero");
	property p_m0_low;
		@(posedge clk_in) disable iff (!nrst_in)
			bus_in.wr && bus_in.addr == `TIT_OFF_CTRL &&
			bus_in.wdata[`TIT_SEL_HI:`TIT_SEL_LO] == 2'h0 &&
			bus_in.wdata[`TIT_ACC_HI:`TIT_ACC_LO] != 2'h0 &&
			bus_in.wdata[`TIT_MODE_HI:`TIT_MODE_LO] == 3'h0 |=> !cnt_out[0];
	endproperty
	a_m0_low: assert property (p_m0_low) else $error("mode 0 not low");
	property p_m2_high;
		@(posedge clk_in) disable iff (!nrst_in)
			bus_in.wr && bus_in.addr == `TIT_OFF_CTRL &&
			bus_in.wdata[`TIT_SEL_HI:`TIT_SEL_LO] == 2'h0 &&
			bus_in.wdata[`TIT_ACC_HI:`TIT_ACC_LO] != 2'h0 && bus_in.wdata[2] |=> cnt_out[0];
	endproperty
	a_m2_high: assert property (p_m2_high) else $error("mode 2 not high");
	property p_tick_gap;
		@(posedge clk_in) disable iff (!nrst_in) tick_r |-> ##10 tick_r;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick period wrong");
	c_trig: cover property (@(posedge clk_in) conv_trig_out);
	c_out0: cover property (@(posedge clk_in) $rose(cnt_out[0]));
	c_rd: cover property (@(posedge clk_in) rd_hit_r && rdata_out != 8'h0);
endmodule

/* tit_timer_test.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module tit_timer_test;
import tit_pkg::*;
logic clk_in, nrst_in, ext_sel, ev_clk, gate0, trig;
logic [2:1] gate12;
logic [7:0] rdata, b, b2;
logic [2:0] cnt, md;
logic [15:0] v;
tit_bus_t bus;
int n_mismatch, comparisons, cyc, ntrig, n, lo, hi;
tit_timer dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus), .rdata_out(rdata),
	.ext_clk_sel_in(ext_sel), .external_event_clock_in(ev_clk),
	.first_counter_gate_in(gate0), .gate_in(gate12), .cnt_out(cnt), .conv_trig_out(trig));
initial begin
	clk_in = 1'b0;
	forever #5 clk_in = ~clk_in;
end
// whole run needs well under 10k cycles; the ceiling leaves room for slow designs
always @(posedge clk_in) begin
	cyc++;
	if (trig === 1'b1) ntrig++;
	if (cyc == 30000) begin
		n_mismatch++;
		conclude();
	end
end
function automatic logic [7:0] cw(input logic [1:0] s, a, input logic [2:0] m, input logic d);
	return {s, a, m, d};
endfunction
function automatic logic is_bcd(input logic [15:0] x);
	return x[3:0] < 10 && x[7:4] < 10 && x[11:8] < 10 && x[15:12] < 10;
endfunction
task automatic cycles(input int k);
	repeat (k) @(posedge clk_in);
endtask
// one gap cycle between strobes keeps each strobe assigned once per time step
task automatic wr(input logic [7:0] a, d);
	@(posedge clk_in);
	bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
	@(posedge clk_in);
	bus.wr <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] d);
	@(posedge clk_in);
	bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
	@(posedge clk_in);
	bus.rd <= 1'b0;
	#1 d = rdata;
endtask
task automatic wait_lvl(input int idx, input logic lv, output int t);
	t = 0;
	while (cnt[idx] === lv && t < 2000) begin
		@(posedge clk_in);
		#1 t++;
	end
endtask
// skips any partial phase first, then measures one whole low phase, and the high phase after it only when eh is above zero
task automatic pulse(input int idx, el, eh, input string nm);
	int t;
	wait_lvl(idx, 1'b0, t);
	wait_lvl(idx, 1'b1, t);
	wait_lvl(idx, 1'b0, t);
	`CHK(nm, el, t)
	if (eh > 0) begin
		wait_lvl(idx, 1'b1, t);
		`CHK(nm, eh, t)
	end
endtask
task automatic ev_edge();
	ev_clk <= 1'b1;
	cycles(4);
	ev_clk <= 1'b0;
	cycles(4);
endtask
task automatic conclude();
	$display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
	if (n_mismatch == 0 && comparisons > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
initial begin
	nrst_in = 1'b0; ext_sel = 1'b0; ev_clk = 1'b0; gate0 = 1'b0; gate12 = 2'b11;
	bus = '0; n_mismatch = 0; comparisons = 0; cyc = 0; ntrig = 0;
	void'($urandom(32'h7dd67ed4));
	repeat (12) @(posedge clk_in);
	#1 `CHK("reset_out", 3'b111, cnt)
	`CHK("reset_trig", 1'b0, trig)
	@(posedge clk_in);
	nrst_in <= 1'b1;
	rd(8'h2c, b); `CHK("ctrl_read", 8'h00, b)
	wr(8'h34, 8'h5a);
	rd(8'h34, b); `CHK("unmapped", 8'h00, b)
	$display("test bus done");
	// gate low holds the loaded count, so the latched value is exact
	wr(8'h2c, cw(2'b00, 2'b11, 3'b000, 1'b0));
	cycles(2); `CHK("m0_init", 1'b0, cnt[0])
	n = $urandom_range(200, 65535);
	wr(8'h20, n[7:0]);
	wr(8'h20, n[15:8]);
	cycles(30);
	wr(8'h2c, 8'h00);
	gate0 <= 1'b1;
	cycles(50);
	rd(8'h20, b);
	rd(8'h20, b2); `CHK("latched", n[15:0], {b2, b})
	wr(8'h2c, 8'he2);
	rd(8'h20, b); `CHK("status_run", 8'h30, b)
	wr(8'h20, 8'h04);
	wr(8'h20, 8'h00);
	cycles(25); `CHK("m0_count", 1'b0, cnt[0])
	cycles(40); `CHK("m0_tc", 1'b1, cnt[0])
	wr(8'h2c, 8'he2);
	rd(8'h20, b); `CHK("status_tc", 8'hb0, b)
	$display("test latch done");
	wr(8'h2c, cw(2'b00, 2'b11, 3'b000, 1'b1));
	wr(8'h20, 8'h00);
	wr(8'h20, 8'h01);
	cycles(60);
	gate0 <= 1'b0;
	cycles(5);
	// read-back form of the count latch, counter zero only
	wr(8'h2c, 8'hd2);
	rd(8'h20, b);
	rd(8'h20, b2);
	v = {b2, b};
	`CHK("bcd", 1'b1, is_bcd(v) && v < 16'h0100 && v > 16'h0080)
	$display("test bcd done");
	gate0 <= 1'b1;
	for (int i = 0; i < 4; i++) begin
		md = {i[1], 1'b1, i[0]};
		n = i[0] ? 2 * $urandom_range(1, 4) + 1 : $urandom_range(2, 9);
		lo = i[0] ? (n - 1) / 2 * 10 : 10;
		hi = i[0] ? (n + 1) / 2 * 10 : (n - 1) * 10;
		wr(8'h2c, cw(2'b00, 2'b01, md, 1'b0));
		wr(8'h20, n[7:0]);
		pulse(0, lo, hi, "periodic");
		if (!i[0]) begin
			gate0 <= 1'b0;
			cycles(14); `CHK("gate_low", 1'b1, cnt[0])
			gate0 <= 1'b1;
		end
	end
	$display("test periodic done");
	for (int i = 0; i < 3; i++) begin
		md = (i == 0) ? 3'b001 : (i == 1) ? 3'b100 : 3'b101;
		n = $urandom_range(2, 9);
		gate0 <= 1'b0;
		wr(8'h2c, cw(2'b00, 2'b01, md, 1'b0));
		wr(8'h20, n[7:0]);
		cycles(20); `CHK("shot_idle", 1'b1, cnt[0])
		gate0 <= 1'b1;
		pulse(0, (i == 0) ? n * 10 : 10, 0, "shot");
	end
	$display("test strobe done");
	wr(8'h2c, cw(2'b01, 2'b01, 3'b010, 1'b0));
	wr(8'h24, 8'h02);
	wr(8'h2c, cw(2'b10, 2'b01, 3'b010, 1'b0));
	wr(8'h28, 8'h02);
	pulse(2, 20, 20, "pacer_out");
	ntrig = 0;
	cycles(400); `CHK("pacer_rate", 1'b1, ntrig >= 9 && ntrig <= 11)
	// counter one gated off starves counter two of clock edges
	gate12 <= 2'b10;
	cycles(100);
	ntrig = 0;
	cycles(200); `CHK("pacer_gate", 0, ntrig)
	gate12 <= 2'b11;
	$display("test pacer done");
	ext_sel <= 1'b1;
	wr(8'h2c, cw(2'b00, 2'b01, 3'b000, 1'b0));
	wr(8'h20, 8'h03);
	cycles(30);
	repeat (3) ev_edge();
	`CHK("event_cnt", 1'b0, cnt[0])
	ev_edge();
	cycles(10); `CHK("event_tc", 1'b1, cnt[0])
	$display("test event done");
	conclude();
end
endmodule
